// file: timer_regs.vh
`ifndef TIMER_REGS_VH
`define TIMER_REGS_VH

// register offsets inside one timer window
`define OFS_CONTROL 8'h00
`define OFS_EVENT 8'h04
`define OFS_STATUS 8'h08
`define OFS_COUNT 8'h0c
`define OFS_PRESCALE 8'h10
`define OFS_RELOAD 8'h14
`define OFS_CHANNEL 8'h18
`define OFS_OPTION 8'h1c

// address layout: bit 8 picks the timer, bits 11:9 must be zero
`define ADDR_TIMER_BIT 8
`define ADDR_HIGH_MSB 11
`define ADDR_HIGH_LSB 9

// control_reg_one fields
`define CTL_RUN 0
`define CTL_UDIS 1
`define CTL_URS 2
`define CTL_MODE_LSB 4
`define CTL_MODE_MSB 5
`define CTL_ARBE 7
`define CTL_EXTCLK 8
`define CTL_DIR 9

// event_generate_reg and status fields
`define EVT_UG 0
`define STS_UPDATE_FLAG 0

// channel_enable_reg fields
`define CHN_EN_LSB 0
`define CHN_EN_MSB 3
`define CHN_OUT_LSB 4
`define CHN_OUT_MSB 7

// counting modes
`define MODE_UP 2'h0
`define MODE_DOWN 2'h1
`define MODE_CENTER 2'h2

// reset values
`define RST_COUNT 16'h0000
`define RST_RELOAD 16'h0000
`define RST_PRESCALE 4'h0
`define RST_NIBBLE 4'h0

`endif

// file: pin_sync.v
`timescale 1ns/1ps
`default_nettype none

module pin_sync (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire din,
  output reg level_q,
  output wire rise
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  reg prev_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_q <= 1'b0;
      prev_q <= 1'b0;
    end else if (ce) begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // change accepted once second and third stage agree
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
      prev_q <= level_q;
    end
  end

  assign rise = level_q & ~prev_q;
endmodule // pin_sync

`default_nettype wire

// file: timer_pair.v
`timescale 1ns/1ps
`default_nettype none
`include "timer_regs.vh"

// Behaviour
// - each timer has a 16-bit counter with reload, counting up, down or both
// - prescaler divides by two to a 4-bit exponent, 16-bit prescale counter
// - prescale exponent writes are buffered, new ratio from next update
// - count, reload and prescale registers readable and writable any time
// - reload buffer copied to shadow at once or on updates, per enable bit
// - overflow or underflow raises update while update disable is low
// - counter advances only on prescaler ticks gated by run enable
// - count gate follows run enable one clock later
// - core debug halt never freezes the counters
// - up mode counts 0 to reload, wraps to 0, signals overflow
// - up mode update on overflow, update generate, or slave request
// - update disable set blocks every update event
// - forced update restarts prescale counter from 0, counter from 0 or from reload in down mode
// - with request select set, software update leaves update flag clear
// - update sets flag and loads prescale and reload shadows
// - enabled output channel overrides other peripheral on its pin
// - second timer remaps each channel from port A to port B
// - external clock and mask pins act only in external clock mode
// - two timers fully independent, no shared counters or registers
// - update generate bit clears itself and reads zero
// - down mode counts reload to 0, reloads, signals underflow
// - center mode: up to reload-1 overflow, down to 1 underflow, then 0
module timer_pair (
  input wire CLK,
  input wire RESETN,
  input wire CE,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  input wire [1:0] SLAVE_UPDATE_REQ,
  input wire [3:0] CH_LEVEL_T1,
  input wire [3:0] CH_LEVEL_T2,
  input wire PIN_PB0_IN,
  input wire PIN_PB5_IN,
  input wire [7:0] PERIPH_PA_OUT,
  input wire [7:0] PERIPH_PA_OE,
  input wire [7:0] PERIPH_PB_OUT,
  input wire [7:0] PERIPH_PB_OE,
  output reg [7:0] PA_OUT,
  output reg [7:0] PA_OE,
  output reg [7:0] PB_OUT,
  output reg [7:0] PB_OE,
  output reg [1:0] UPDATE_PULSE
);
  localparam [11:0] T2_PA_PIN = {3'd2, 3'd1, 3'd3, 3'd0};
  localparam [11:0] T2_PB_PIN = {3'd4, 3'd3, 3'd2, 3'd1};

  reg rst_s1_q;
  reg rst_n_q;
  wire pb0_level;
  wire pb0_rise;
  wire pb5_level;
  wire pb5_rise;
  wire [63:0] rd_all;
  wire [1:0] hit_all;
  wire [1:0] uev_all;
  wire [7:0] own_all;
  wire [3:0] remap_sel;
  reg [31:0] rd_sel;
  reg err_d;
  reg [7:0] own_a;
  reg [7:0] lvl_a;
  reg [7:0] own_b;
  reg [7:0] lvl_b;
  integer c;

  wire [7:0] offset = PADDR[7:0];
  wire timer_bit = PADDR[`ADDR_TIMER_BIT];
  wire setup = PSEL & ~PENABLE;
  wire access = PSEL & PENABLE & PREADY;
  wire wr_ok = access & PWRITE & ~PSLVERR;

  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  pin_sync sync_pb0 (
    .clk(CLK),
    .rst_n(rst_n_q),
    .ce(CE),
    .din(PIN_PB0_IN),
    .level_q(pb0_level),
    .rise(pb0_rise)
  );

  pin_sync sync_pb5 (
    .clk(CLK),
    .rst_n(rst_n_q),
    .ce(CE),
    .din(PIN_PB5_IN),
    .level_q(pb5_level),
    .rise(pb5_rise)
  );

  genvar t;
  generate
    for (t = 0; t < 2; t = t + 1) begin : tmr
      // each instance owns all of its state
      reg cen_q;
      reg udis_q;
      reg urs_q;
      reg arbe_q;
      reg ext_q;
      reg dir_q;
      reg dir_d;
      reg gate_q;
      reg flag_q;
      reg [1:0] mode_q;
      reg [15:0] cnt_q;
      reg [15:0] cnt_d;
      reg [15:0] pcnt_q;
      reg [15:0] pcnt_d;
      reg [15:0] arr_buf_q;
      reg [15:0] arr_act_q;
      reg [3:0] psc_buf_q;
      reg [3:0] psc_act_q;
      reg [3:0] ch_en_q;
      reg [3:0] ch_out_q;
      reg [3:0] remap_q;
      reg [31:0] rd_d;
      reg hit_d;

      wire mine = wr_ok & (timer_bit == (t == 1));
      wire wr_ctrl = mine & (offset == `OFS_CONTROL);
      wire wr_evt = mine & (offset == `OFS_EVENT);
      wire wr_sts = mine & (offset == `OFS_STATUS);
      wire wr_cnt = mine & (offset == `OFS_COUNT);
      wire wr_psc = mine & (offset == `OFS_PRESCALE);
      wire wr_arr = mine & (offset == `OFS_RELOAD);
      wire wr_chn = mine & (offset == `OFS_CHANNEL);
      wire wr_opt = mine & (offset == `OFS_OPTION) & (t == 1);
      // update generate is a write pulse, nothing is stored
      wire ug = wr_evt & PWDATA[`EVT_UG];
      wire ext_rise = (t == 0) ? pb0_rise : pb5_rise;
      wire ext_mask = (t == 0) ? pb5_level : pb0_level;
      // pins ignored unless external clock mode
      wire psc_in = ext_q ? (ext_rise & ext_mask) : 1'b1;
      wire [15:0] pmax = (16'h0001 << psc_act_q) - 16'h0001;
      wire pwrap = pcnt_q >= pmax;
      // gate lags run enable; no debug halt term exists
      wire tick = gate_q & psc_in & pwrap;
      // unbuffered reload acts straight from the buffer
      wire [15:0] arr_eff = arbe_q ? arr_act_q : arr_buf_q;
      wire arr_nz = arr_eff != 16'h0000;
      wire ovf = tick & (((mode_q == `MODE_UP) & (cnt_q == arr_eff)) |
        ((mode_q == `MODE_CENTER) & ~dir_q & arr_nz &
        (cnt_q == arr_eff - 16'h0001)));
      wire unf = tick & (((mode_q == `MODE_DOWN) & (cnt_q == 16'h0000)) |
        ((mode_q == `MODE_CENTER) & dir_q &
        (cnt_q == 16'h0001)));
      wire forced = ug | SLAVE_UPDATE_REQ[t];
      // update disable blocks all sources
      wire update_event = ~udis_q & (ovf | unf | forced);
      wire flag_set = update_event & ~(urs_q & ug);
      // reload shadow is refreshed before the counter reloads
      wire [15:0] arr_next = update_event ? arr_buf_q : arr_eff;

      always @* begin
        cnt_d = cnt_q;
        dir_d = (mode_q == `MODE_CENTER) ? dir_q : 1'b0;
        pcnt_d = pcnt_q;
        if (update_event & forced) begin
          // restart both counters; ratio reloads from the prescale buffer
          cnt_d = (mode_q == `MODE_DOWN) ? arr_next : 16'h0000;
          dir_d = 1'b0;
          pcnt_d = 16'h0000;
        end else begin
          if (wr_cnt) begin
            cnt_d = PWDATA[15:0];
          end else if (tick) begin
            case (mode_q)
              `MODE_UP: cnt_d = ovf ? 16'h0000 : cnt_q + 16'h0001;
              `MODE_DOWN: cnt_d = unf ? arr_next : cnt_q - 16'h0001;
              `MODE_CENTER: begin
                if (!arr_nz) begin
                  cnt_d = 16'h0000;
                end else if (!dir_q) begin
                  cnt_d = cnt_q + 16'h0001;
                  dir_d = ovf;
                end else begin
                  cnt_d = cnt_q - 16'h0001;
                  dir_d = ~unf;
                end
              end
              default: cnt_d = cnt_q;
            endcase
          end
          if (gate_q & psc_in) begin
            pcnt_d = pwrap ? 16'h0000 : pcnt_q + 16'h0001;
          end
        end
      end

      always @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
          cen_q <= 1'b0;
          udis_q <= 1'b0;
          urs_q <= 1'b0;
          arbe_q <= 1'b0;
          ext_q <= 1'b0;
          dir_q <= 1'b0;
          gate_q <= 1'b0;
          flag_q <= 1'b0;
          mode_q <= `MODE_UP;
          cnt_q <= `RST_COUNT;
          pcnt_q <= 16'h0000;
          arr_buf_q <= `RST_RELOAD;
          arr_act_q <= `RST_RELOAD;
          psc_buf_q <= `RST_PRESCALE;
          psc_act_q <= `RST_PRESCALE;
          ch_en_q <= `RST_NIBBLE;
          ch_out_q <= `RST_NIBBLE;
          remap_q <= `RST_NIBBLE;
        end else if (CE) begin
          if (wr_ctrl) begin
            cen_q <= PWDATA[`CTL_RUN];
            udis_q <= PWDATA[`CTL_UDIS];
            urs_q <= PWDATA[`CTL_URS];
            mode_q <= PWDATA[`CTL_MODE_MSB:`CTL_MODE_LSB];
            arbe_q <= PWDATA[`CTL_ARBE];
            ext_q <= PWDATA[`CTL_EXTCLK];
          end
          gate_q <= cen_q;
          cnt_q <= cnt_d;
          dir_q <= dir_d;
          pcnt_q <= pcnt_d;
          // set beats a same-cycle write-one clear
          flag_q <= flag_set |
            (flag_q & ~(wr_sts & PWDATA[`STS_UPDATE_FLAG]));
          if (wr_psc) psc_buf_q <= PWDATA[3:0];
          if (update_event) psc_act_q <= psc_buf_q;
          if (wr_arr) arr_buf_q <= PWDATA[15:0];
          if (update_event | ~arbe_q) arr_act_q <= arr_buf_q;
          if (wr_chn) begin
            ch_en_q <= PWDATA[`CHN_EN_MSB:`CHN_EN_LSB];
            ch_out_q <= PWDATA[`CHN_OUT_MSB:`CHN_OUT_LSB];
          end
          if (wr_opt) remap_q <= PWDATA[3:0];
        end
      end

      always @* begin
        rd_d = 32'h00000000;
        hit_d = 1'b1;
        if (offset == `OFS_CONTROL) begin
          rd_d[`CTL_RUN] = cen_q;
          rd_d[`CTL_UDIS] = udis_q;
          rd_d[`CTL_URS] = urs_q;
          rd_d[`CTL_MODE_MSB:`CTL_MODE_LSB] = mode_q;
          rd_d[`CTL_ARBE] = arbe_q;
          rd_d[`CTL_EXTCLK] = ext_q;
          rd_d[`CTL_DIR] = dir_q;
        end else if (offset == `OFS_EVENT) begin
          rd_d = 32'h00000000;
        end else if (offset == `OFS_STATUS) begin
          rd_d[`STS_UPDATE_FLAG] = flag_q;
        end else if (offset == `OFS_COUNT) begin
          rd_d[15:0] = cnt_q;
        end else if (offset == `OFS_PRESCALE) begin
          rd_d[3:0] = psc_buf_q;
        end else if (offset == `OFS_RELOAD) begin
          rd_d[15:0] = arr_buf_q;
        end else if (offset == `OFS_CHANNEL) begin
          rd_d[`CHN_EN_MSB:`CHN_EN_LSB] = ch_en_q;
          rd_d[`CHN_OUT_MSB:`CHN_OUT_LSB] = ch_out_q;
        end else if ((offset == `OFS_OPTION) && (t == 1)) begin
          rd_d[3:0] = remap_q;
        end else begin
          hit_d = 1'b0;
        end
      end

      assign rd_all[32 * t +: 32] = rd_d;
      assign hit_all[t] = hit_d;
      assign uev_all[t] = update_event;
      assign own_all[4 * t +: 4] = ch_en_q & ch_out_q;
      if (t == 1) begin : opt
        assign remap_sel = remap_q;
      end
    end
  endgenerate

  always @* begin
    rd_sel = timer_bit ? rd_all[63:32] : rd_all[31:0];
    err_d = (PADDR[`ADDR_HIGH_MSB:`ADDR_HIGH_LSB] != 3'h0) |
      ~hit_all[timer_bit];
  end

  // zero-wait slave: ready rises in the access cycle
  always @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else if (CE) begin
      if (setup) begin
        PREADY <= 1'b1;
        PSLVERR <= err_d;
        PRDATA <= (PWRITE | err_d) ? 32'h00000000 : rd_sel;
      end else begin
        PREADY <= 1'b0;
        PSLVERR <= 1'b0;
        PRDATA <= 32'h00000000;
      end
    end
  end

  // pin ownership: first timer fixed, second timer remappable
  always @* begin
    own_a = 8'h00;
    lvl_a = 8'h00;
    own_b = 8'h00;
    lvl_b = 8'h00;
    own_b[6] = own_all[0];
    lvl_b[6] = CH_LEVEL_T1[0];
    own_b[7] = own_all[1];
    lvl_b[7] = CH_LEVEL_T1[1];
    own_a[6] = own_all[2];
    lvl_a[6] = CH_LEVEL_T1[2];
    own_a[7] = own_all[3];
    lvl_a[7] = CH_LEVEL_T1[3];
    for (c = 0; c < 4; c = c + 1) begin
      if (remap_sel[c]) begin
        own_b[T2_PB_PIN[3 * c +: 3]] = own_all[4 + c];
        lvl_b[T2_PB_PIN[3 * c +: 3]] = CH_LEVEL_T2[c];
      end else begin
        own_a[T2_PA_PIN[3 * c +: 3]] = own_all[4 + c];
        lvl_a[T2_PA_PIN[3 * c +: 3]] = CH_LEVEL_T2[c];
      end
    end
  end

  always @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      PA_OUT <= 8'h00;
      PA_OE <= 8'h00;
      PB_OUT <= 8'h00;
      PB_OE <= 8'h00;
      UPDATE_PULSE <= 2'h0;
    end else if (CE) begin
      // timer channel wins over any other user of the pin
      PA_OUT <= (own_a & lvl_a) | (~own_a & PERIPH_PA_OUT);
      PA_OE <= own_a | PERIPH_PA_OE;
      PB_OUT <= (own_b & lvl_b) | (~own_b & PERIPH_PB_OUT);
      PB_OE <= own_b | PERIPH_PB_OE;
      UPDATE_PULSE <= uev_all;
    end
  end
endmodule // timer_pair

`default_nettype wire

// file: timer_pair_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module timer_pair_checker (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [3:0] CH_LEVEL_T1,
  input wire logic [7:0] PERIPH_PB_OE,
  input wire logic [7:0] PB_OUT,
  input wire logic [7:0] PB_OE,
  input wire logic [1:0] UPDATE_PULSE
);
  logic udis_q;
  logic own6_q;
  wire setup = PSEL && !PENABLE;
  wire wdone = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
  // mirror of first timer update disable and channel 0 ownership
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      udis_q <= 1'b0;
      own6_q <= 1'b0;
    end else if (wdone && PADDR == 12'h000) begin
      udis_q <= PWDATA[1];
    end else if (wdone && PADDR == 12'h018) begin
      own6_q <= PWDATA[0] && PWDATA[4];
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  a_ready_after_setup: assert property (setup |=> PREADY)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (PREADY |-> PENABLE ##1 !PREADY)
    else $error("ready not a single access cycle");
  a_err_high_addr: assert property (setup && PADDR[11:9] != 3'h0
    |=> PSLVERR && PRDATA == 32'h0)
    else $error("high address not refused");
  a_err_option_first: assert property (setup && PADDR[8:0] == 9'h01c
    |=> PSLVERR) else $error("option on first timer not refused");
  a_rdata_idle_zero: assert property (!PREADY |-> PRDATA == 32'h0
    && !PSLVERR) else $error("read data outside access");
  a_ug_reads_zero: assert property (setup && !PWRITE
    && PADDR == 12'h004 |=> PRDATA == 32'h0)
    else $error("update generate reads nonzero");
  a_ug_gives_update: assert property (wdone && PADDR == 12'h004
    && PWDATA[0] && !udis_q |-> ##[1:3] UPDATE_PULSE[0])
    else $error("update generate without update");
  a_udis_blocks: assert property (udis_q && $past(udis_q)
    && $past(udis_q, 2) |-> !UPDATE_PULSE[0])
    else $error("update while disabled");
  a_pin_owned: assert property (own6_q |=> PB_OE[6]
    && PB_OUT[6] == $past(CH_LEVEL_T1[0]))
    else $error("owned pin not driven by channel");
  a_pin_free: assert property (!own6_q
    |=> PB_OE[6] == $past(PERIPH_PB_OE[6]))
    else $error("free pin not left to peripheral");
  cover property (wdone && PADDR == 12'h004);
  cover property (PSLVERR);
  cover property (own6_q ##1 PB_OE[6]);
endmodule // timer_pair_checker
bind timer_pair timer_pair_checker timer_pair_checker_i (.CLK(CLK),
  .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .CH_LEVEL_T1(CH_LEVEL_T1), .PB_OUT(PB_OUT),
  .PERIPH_PB_OE(PERIPH_PB_OE), .PB_OE(PB_OE), .UPDATE_PULSE(UPDATE_PULSE));
`default_nettype wire

// file: tb_timer_pair.sv
`timescale 1ns/1ps
`default_nettype none
module tb_timer_pair;
  logic clk, rst_n, ce, psel, penable, pwrite, pin0, pin5, err_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, rdata_q;
  logic [1:0] slave_req;
  logic [3:0] lvl1, lvl2;
  logic [7:0] pa_out_o, pa_oe_o, pb_out_o, pb_oe_o;
  wire [31:0] prdata;
  wire pready, pslverr;
  wire [7:0] pa_out, pa_oe, pb_out, pb_oe;
  wire [1:0] upd;
  integer miscompares, num_checks, pulses, pulses2, n, i, j;
  timer_pair timer_pair_i (.CLK(clk), .RESETN(rst_n), .CE(ce),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SLAVE_UPDATE_REQ(slave_req), .CH_LEVEL_T1(lvl1), .CH_LEVEL_T2(lvl2),
    .PIN_PB0_IN(pin0), .PIN_PB5_IN(pin5), .PERIPH_PA_OUT(pa_out_o),
    .PERIPH_PA_OE(pa_oe_o), .PERIPH_PB_OUT(pb_out_o),
    .PERIPH_PB_OE(pb_oe_o), .PA_OUT(pa_out), .PA_OE(pa_oe),
    .PB_OUT(pb_out), .PB_OE(pb_oe), .UPDATE_PULSE(upd));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    if (upd[0] === 1'b1) pulses <= pulses + 1;
    if (upd[1] === 1'b1) pulses2 <= pulses2 + 1;
  end
  task test_done;
    begin
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input [31:0] e, input [31:0] g, input string nm);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("wrong value %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // one transfer, idle cycle first so release and next setup never clash
  task apb(input [11:0] a, input w, input [31:0] d);
    begin
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
        @(posedge clk);
      end while (pready !== 1'b1);
      rdata_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rd(input [11:0] a, input [31:0] e, input string nm);
    begin
      apb(a, 1'b0, 32'h0);
      chk(e, rdata_q, nm);
    end
  endtask
  // cycles between two update pulses of the first timer
  task gap(output integer g);
    integer k;
    begin
      k = 0;
      while (upd[0] !== 1'b1 && k < 5000) begin
        @(posedge clk);
        k = k + 1;
      end
      @(posedge clk);
      g = 1;
      while (upd[0] !== 1'b1 && g < 5000) begin
        @(posedge clk);
        g = g + 1;
      end
    end
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    miscompares = miscompares + 1;
    test_done;
  end
  initial begin
    rst_n = 1'b0; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h0; pwdata = 32'h0; pin0 = 1'b0; pin5 = 1'b0;
    slave_req = 2'h0; lvl1 = 4'h0; lvl2 = 4'h0; pa_out_o = 8'h0;
    pa_oe_o = 8'h0; pb_out_o = 8'h0; pb_oe_o = 8'h0;
    miscompares = 0; num_checks = 0; pulses = 0; pulses2 = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (i = 0; i < 2; i++)
      for (j = 0; j < 7; j++) rd(12'(i * 256 + j * 4), 0, "reset");
    rd(12'h11c, 0, "option reset");
    apb(12'h01c, 1'b0, 32'h0);
    chk(1, {31'h0, err_q}, "option err");
    apb(12'h214, 1'b1, 32'h5);
    chk(1, {31'h0, err_q}, "high err");
    rd(12'h014, 0, "ignored write");
    $display("test access done");
    apb(12'h014, 1'b1, 32'h1234);
    rd(12'h014, 32'h1234, "reload");
    apb(12'h010, 1'b1, 32'hf);
    rd(12'h010, 32'hf, "prescale");
    apb(12'h00c, 1'b1, 32'hab);
    rd(12'h00c, 32'hab, "held count");
    rd(12'h114, 0, "other reload");
    apb(12'h010, 1'b1, 32'h0);
    apb(12'h00c, 1'b1, 32'h0);
    apb(12'h014, 1'b1, 32'h3);
    apb(12'h000, 1'b1, 32'h1);
    gap(n);
    gap(n);
    chk(4, n, "period");
    rd(12'h008, 1, "flag");
    apb(12'h010, 1'b1, 32'h1);
    gap(n);
    gap(n);
    chk(8, n, "prescaled period");
    apb(12'h000, 1'b1, 32'h83);
    apb(12'h014, 1'b1, 32'h1);
    apb(12'h010, 1'b1, 32'h0);
    repeat (3) @(posedge clk);
    n = pulses;
    repeat (40) @(posedge clk);
    chk(n, pulses, "disabled");
    apb(12'h000, 1'b1, 32'h81);
    gap(n);
    gap(n);
    chk(2, n, "buffered period");
    $display("test counting done");
    apb(12'h000, 1'b1, 32'h4);
    apb(12'h008, 1'b1, 32'h1);
    apb(12'h00c, 1'b1, 32'h33);
    n = pulses;
    apb(12'h004, 1'b1, 32'h1);
    repeat (3) @(posedge clk);
    chk(n + 1, pulses, "ug pulse");
    rd(12'h00c, 0, "ug count");
    rd(12'h008, 0, "urs flag");
    rd(12'h004, 0, "ug reads");
    apb(12'h000, 1'b1, 32'h0);
    apb(12'h00c, 1'b1, 32'h22);
    slave_req <= 2'h1;
    @(posedge clk);
    slave_req <= 2'h0;
    repeat (3) @(posedge clk);
    rd(12'h00c, 0, "slave count");
    rd(12'h008, 1, "slave flag");
    chk(0, pulses2, "second idle");
    n = pulses;
    slave_req <= 2'h2;
    @(posedge clk);
    slave_req <= 2'h0;
    repeat (3) @(posedge clk);
    chk(1, pulses2, "second pulse");
    chk(n, pulses, "first untouched");
    apb(12'h014, 1'b1, 32'hffff);
    apb(12'h000, 1'b1, 32'h1);
    apb(12'h00c, 1'b0, 32'h0);
    n = rdata_q;
    rd(12'h00c, n + 3, "running count");
    n = rdata_q;
    ce <= 1'b0;
    repeat (5) @(posedge clk);
    ce <= 1'b1;
    rd(12'h00c, n + 3, "frozen count");
    apb(12'h000, 1'b1, 32'h0);
    repeat (3) @(posedge clk);
    apb(12'h00c, 1'b0, 32'h0);
    n = rdata_q;
    rd(12'h00c, n, "stopped count");
    $display("test update done");
    apb(12'h00c, 1'b1, 32'h0);
    apb(12'h000, 1'b1, 32'h101);
    for (i = 0; i < 2; i++) begin
      pin5 <= (i == 0);
      repeat (5) begin
        repeat (4) @(posedge clk);
        pin0 <= 1'b1;
        repeat (4) @(posedge clk);
        pin0 <= 1'b0;
      end
      repeat (6) @(posedge clk);
      rd(12'h00c, 5, "ext count");
    end
    $display("test ext clock done");
    apb(12'h014, 1'b1, 32'h3);
    apb(12'h000, 1'b1, 32'h10);
    apb(12'h004, 1'b1, 32'h1);
    rd(12'h00c, 3, "down restart");
    apb(12'h000, 1'b1, 32'h11);
    gap(n);
    gap(n);
    chk(4, n, "down period");
    apb(12'h000, 1'b1, 32'h20);
    apb(12'h004, 1'b1, 32'h1);
    apb(12'h000, 1'b1, 32'h21);
    gap(n);
    gap(n);
    chk(3, n, "center period");
    $display("test modes done");
    pb_oe_o <= 8'hff;
    pa_out_o <= 8'hff;
    lvl1 <= 4'h5;
    apb(12'h018, 1'b1, 32'h11);
    apb(12'h11c, 1'b1, 32'h1);
    apb(12'h118, 1'b1, 32'h11);
    repeat (2) @(posedge clk);
    chk(8'hff, pb_oe, "pb oe");
    chk(8'h40, pb_out, "pb out");
    chk(8'h00, pa_oe, "pa oe");
    apb(12'h11c, 1'b1, 32'h0);
    repeat (2) @(posedge clk);
    chk(8'h01, pa_oe, "pa0 oe");
    chk(8'hfe, pa_out, "pa0 out");
    $display("test pins done");
    test_done;
  end
endmodule // tb_timer_pair
`default_nettype wire
